// ---- rtl/clerr_flags.sv ----
// clerr_flags: contactless error flags, link state code and collision position,
// readable over AXI4-Lite, plus the error event request and fifo/receive gating.
// assumes the event struct is synchronous to aclk and its strobes are pulses.
//
// Functional notes
// - error bit 7 reflects failure of the most recent nonvolatile-memory command
// - bit 6 sets on fifo write during crc, receive phases or authentication
// - bit 6 clears at command start, or after error flags reach fifo in multi-frame
// - fifo write while full sets bit 5; later writes are discarded
// - bit 4 sets when fewer than four data bits follow a valid start-of-frame
// - short frames are dropped silently, decoder stays armed; emd extends this to 3 bytes
// - bits 4,2,1,0 clear at receive start or transceive entering wait-for-data
// - bit 3 sets when transmission needs data and the fifo is empty
// - bit 2 sets on collision; first collision position is recorded
// - a collision inside the end-of-frame symbol does not set bit 2
// - bit 1 sets on bad stop bit, start-of-frame or byte count; reception stops
// - on a protocol error the last received byte is not stored
// - bit 0 sets on parity or crc mismatch; reception continues
// - with collision-as-integrity set, a collision also sets bit 0
// - status bits 2..0 report the link state code, upper bits read zero
// - error event request rises when bits 6,5,3,1 or 0 become set
// - collision position counts data bits of the frame from zero
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module clerr_flags
	import clerr_pkg::*;
#(
	parameter int ADDR_W     = 8,
	parameter int MIN_BITS   = MIN_FRAME_BITS,
	parameter int EMD_BYTES  = EMD_MIN_BYTES
)
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite register bus
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// events from the contactless path
	input  wire clerr_evt_t        evt,
	// results to the device
	output logic [7:0]             link_error_flags,
	output clerr_state_t           link_state_code,
	output logic                   error_event_request,
	output logic                   receive_done_event,
	output logic                   fifo_write_allow,
	output logic                   byte_store,
	output logic                   rx_halt
);

	if (MIN_BITS < 1 || EMD_BYTES < 1 || EMD_BYTES * 8 >= (1 << BIT_CNT_W))
		$error("clerr_flags: frame length limits out of range");

	logic                 wr_en;
	logic [ADDR_W-1:0]    wr_addr;
	logic [31:0]          wr_data;
	logic [3:0]           wr_strb;
	logic                 wr_hit;
	logic [31:0]          rd_data;
	logic                 rd_hit;
	logic [CTRL_W-1:0]    ctrl_r;
	logic [7:0]           flags_nxt;
	logic [7:0]           set_v;
	logic [7:0]           clr_v;
	logic [BIT_CNT_W-1:0] bitcnt_r;
	logic [6:0]           coll_pos_r;
	logic                 coll_valid_r;
	logic                 coll_seen_r;
	logic                 pend_r;
	logic                 enter_wd;
	logic                 in_rx;
	logic                 recv;
	logic                 coll_hit;
	logic                 prot;
	logic                 end_now;
	logic                 short_now;
	logic                 drop;
	logic                 frame_ok;
	logic                 rx_clr;
	logic                 byte_in;
	logic                 store_now;

	// bus slave
	clerr_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_hit        (wr_hit),
		.rd_data       (rd_data),
		.rd_hit        (rd_hit)
	);

	// link state machine
	clerr_state_track u_state (
		.aclk                (aclk),
		.aresetn             (aresetn),
		.evt                 (evt),
		.multi_frame_receive (ctrl_r[CTRL_MULTI_BIT]),
		.frame_ok            (frame_ok),
		.frame_drop          (drop),
		.rx_halt             (prot),
		.state_r             (link_state_code),
		.trx_r               (),
		.enter_wait_data     (enter_wd)
	);

	// register decode; error, status and collision words are read-only
	function automatic logic [32:0] decode(input logic [ADDR_W-1:0] a);
		logic [32:0] r;
		r = 33'h0;
		if (a[ADDR_W-1:2] == (ADDR_W-2)'(ERR_IDX))
			r = {1'b1, 24'h0, link_error_flags};
		else if (a[ADDR_W-1:2] == (ADDR_W-2)'(STAT_IDX))
			r = {1'b1, 29'h0, link_state_code};
		else if (a[ADDR_W-1:2] == (ADDR_W-2)'(COLL_IDX))
			r = {1'b1, 24'h0, coll_valid_r, coll_pos_r};
		else if (a[ADDR_W-1:2] == (ADDR_W-2)'(CTRL_IDX))
			r = {1'b1, 29'h0, ctrl_r};
		return r;
	endfunction

	assign {rd_hit, rd_data} = decode(s_axi_araddr);
	assign wr_hit = decode(wr_addr) >> 32 != 33'h0;

	// control register: multi-frame, collision-as-integrity, emd suppression
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= CTRL_RESET;
		else if (wr_en && wr_strb[0] && wr_addr[ADDR_W-1:2] == (ADDR_W-2)'(CTRL_IDX))
			ctrl_r <= wr_data[CTRL_W-1:0];
	end

	// receive-path qualifiers
	assign recv      = link_state_code == ST_RECV;
	assign in_rx     = recv || link_state_code == ST_WAIT_DATA;
	assign coll_hit  = recv && evt.rx_coll && !evt.rx_coll_eof;
	assign prot      = in_rx && (evt.rx_stop_err || evt.rx_sof_err || evt.rx_len_err);
	assign end_now   = recv && evt.rx_end && !prot;
	assign short_now = end_now && bitcnt_r < BIT_CNT_W'(MIN_BITS);
	assign drop      = short_now || (end_now && ctrl_r[CTRL_EMD_BIT]
		&& bitcnt_r < BIT_CNT_W'(EMD_BYTES * 8));
	assign frame_ok  = end_now && !drop;
	assign rx_clr    = (evt.cmd_start && evt.cmd_kind == CMD_RX) || enter_wd;
	assign byte_in   = recv && evt.rx_byte;
	assign store_now = pend_r && !prot && (byte_in || frame_ok);

	// flag set terms
	always_comb
	begin
		set_v = 8'h00;
		set_v[ERR_NVM_BIT]   = evt.nvm_done && evt.nvm_fail;
		set_v[ERR_WRCF_BIT]  = evt.fifo_wr && (evt.tx_crc_active || evt.auth_active
			|| in_rx || link_state_code == ST_RX_WAIT);
		set_v[ERR_OVFL_BIT]  = evt.fifo_wr && evt.fifo_full;
		set_v[ERR_SHORT_BIT] = short_now;
		set_v[ERR_NODAT_BIT] = evt.tx_need_data && evt.fifo_empty;
		set_v[ERR_COLL_BIT]  = coll_hit;
		set_v[ERR_PROT_BIT]  = prot;
		set_v[ERR_INTEG_BIT] = (recv && (evt.rx_parity_err || evt.rx_crc_err))
			|| (coll_hit && ctrl_r[CTRL_CINT_BIT]);
	end

	// flag clear terms; a set in the same cycle wins
	always_comb
	begin
		clr_v = rx_clr ? ERR_RX_MASK : 8'h00;
		clr_v[ERR_NVM_BIT]   = evt.nvm_done && !evt.nvm_fail;
		clr_v[ERR_WRCF_BIT]  = ctrl_r[CTRL_MULTI_BIT] ? evt.err_to_fifo
			: evt.cmd_start;
		clr_v[ERR_OVFL_BIT]  = evt.cmd_start;
		clr_v[ERR_NODAT_BIT] = evt.cmd_start;
	end

	assign flags_nxt = (link_error_flags & ~clr_v) | set_v;

	// error flags and the flag-derived outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			link_error_flags    <= ERR_RESET;
			error_event_request <= 1'b0;
			fifo_write_allow    <= 1'b1;
		end
		else
		begin
			link_error_flags    <= flags_nxt;
			error_event_request <= |(set_v & ~link_error_flags & ERR_REQ_MASK);
			fifo_write_allow    <= !flags_nxt[ERR_OVFL_BIT];
		end
	end

	// data-bit count of the current frame, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bitcnt_r <= '0;
		else if (evt.rx_sof && link_state_code == ST_WAIT_DATA)
			bitcnt_r <= '0;
		else if (recv && evt.rx_bit && bitcnt_r != '1)
			bitcnt_r <= bitcnt_r + 1'b1;
	end

	// first collision position; only the first 64 data bits are representable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			coll_seen_r  <= 1'b0;
			coll_pos_r   <= 7'h00;
			coll_valid_r <= 1'b0;
		end
		else if (coll_hit && !coll_seen_r)
		begin
			coll_seen_r  <= 1'b1;
			coll_pos_r   <= bitcnt_r[6:0];
			coll_valid_r <= bitcnt_r < BIT_CNT_W'(COLL_POS_BITS);
		end
		else if (rx_clr || (evt.rx_sof && link_state_code == ST_WAIT_DATA))
		begin
			coll_seen_r  <= 1'b0;
			coll_pos_r   <= 7'h00;
			coll_valid_r <= 1'b0;
		end
	end

	// one byte is held back until the next byte or a clean frame end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pend_r <= 1'b0;
		else if (prot || drop || (evt.rx_sof && link_state_code == ST_WAIT_DATA))
			pend_r <= 1'b0;
		else if (byte_in)
			pend_r <= 1'b1;
		else if (frame_ok)
			pend_r <= 1'b0;
	end

	// receive-side strobes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			receive_done_event <= 1'b0;
			byte_store         <= 1'b0;
			rx_halt            <= 1'b0;
		end
		else
		begin
			receive_done_event <= frame_ok;
			byte_store         <= store_now;
			rx_halt            <= prot;
		end
	end

	// checks
	property p_nvm;
		@(posedge aclk) disable iff (!aresetn)
		evt.nvm_done && evt.nvm_fail |=> link_error_flags[7];
	endproperty
	a_nvm: assert property (p_nvm) else $error("nvm error flag not set");

	property p_wrcf;
		@(posedge aclk) disable iff (!aresetn)
		evt.fifo_wr && link_state_code inside {ST_RX_WAIT, ST_WAIT_DATA, ST_RECV}
		|=> link_error_flags[6] && error_event_request | $past(link_error_flags[6]);
	endproperty
	a_wrcf: assert property (p_wrcf) else $error("write conflict not flagged");

	property p_wrcf_clr;
		@(posedge aclk) disable iff (!aresetn)
		evt.cmd_start && !ctrl_r[0] && !evt.fifo_wr && !evt.tx_crc_active
		&& !evt.auth_active && !in_rx && link_state_code != ST_RX_WAIT
		|=> !link_error_flags[6];
	endproperty
	a_wrcf_clr: assert property (p_wrcf_clr) else $error("write conflict not cleared");

	property p_ovfl;
		@(posedge aclk) disable iff (!aresetn)
		evt.fifo_wr && evt.fifo_full |=> link_error_flags[5] && !fifo_write_allow;
	endproperty
	a_ovfl: assert property (p_ovfl) else $error("overflow not blocking writes");

	property p_short;
		@(posedge aclk) disable iff (!aresetn)
		recv && evt.rx_end && !prot && bitcnt_r < BIT_CNT_W'(MIN_BITS)
			&& !evt.cmd_start && !evt.cmd_stop
		|=> link_error_flags[4] && !receive_done_event && link_state_code == ST_WAIT_DATA;
	endproperty
	a_short: assert property (p_short) else $error("short frame mishandled");

	property p_rxclr;
		@(posedge aclk) disable iff (!aresetn)
		evt.cmd_start && evt.cmd_kind == CMD_RX && !recv |=> (link_error_flags & 8'h17) == 8'h00;
	endproperty
	a_rxclr: assert property (p_rxclr) else $error("receive flags not cleared");

	property p_nodata;
		@(posedge aclk) disable iff (!aresetn)
		evt.tx_need_data && evt.fifo_empty |=> link_error_flags[3];
	endproperty
	a_nodata: assert property (p_nodata) else $error("empty transmit not flagged");

	property p_coll_eof;
		@(posedge aclk) disable iff (!aresetn)
		evt.rx_coll && evt.rx_coll_eof && !link_error_flags[2] |=> !link_error_flags[2];
	endproperty
	a_coll_eof: assert property (p_coll_eof) else $error("eof collision flagged");

	property p_prot;
		@(posedge aclk) disable iff (!aresetn)
		prot |=> link_error_flags[1] && rx_halt && !byte_store
			&& link_state_code != ST_RECV;
	endproperty
	a_prot: assert property (p_prot) else $error("protocol error not handled");

	property p_integ;
		@(posedge aclk) disable iff (!aresetn)
		recv && evt.rx_parity_err || coll_hit && ctrl_r[1] |=> link_error_flags[0];
	endproperty
	a_integ: assert property (p_integ) else $error("integrity error not flagged");

	property p_state_code;
		@(posedge aclk) disable iff (!aresetn)
		link_state_code != 3'h4;
	endproperty
	a_state_code: assert property (p_state_code) else $error("unused state code");

	property p_req;
		@(posedge aclk) disable iff (!aresetn)
		$rose(link_error_flags[0]) || $rose(link_error_flags[1]) |-> error_event_request;
	endproperty
	a_req: assert property (p_req) else $error("error request missing");

endmodule

// ---- pkg/clerr_pkg.sv ----
// clerr_pkg: register map, flag positions, link states and event carriers for
// the contactless error/status register bank.
// assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
package clerr_pkg;

	// register indices; byte address is four times the index
	localparam int ERR_IDX  = 'h0a;
	localparam int STAT_IDX = 'h0b;
	localparam int COLL_IDX = 'h0d;
	localparam int CTRL_IDX = 'h10;

	// error register bit positions
	localparam int ERR_NVM_BIT   = 7;
	localparam int ERR_WRCF_BIT  = 6;
	localparam int ERR_OVFL_BIT  = 5;
	localparam int ERR_SHORT_BIT = 4;
	localparam int ERR_NODAT_BIT = 3;
	localparam int ERR_COLL_BIT  = 2;
	localparam int ERR_PROT_BIT  = 1;
	localparam int ERR_INTEG_BIT = 0;

	// flags that raise the error event request
	localparam logic [7:0] ERR_REQ_MASK = 8'h6b;
	// flags cleared at receive start
	localparam logic [7:0] ERR_RX_MASK  = 8'h17;

	// control register bit positions and reset value
	localparam int         CTRL_MULTI_BIT = 0;
	localparam int         CTRL_CINT_BIT  = 1;
	localparam int         CTRL_EMD_BIT   = 2;
	localparam int         CTRL_W         = 3;
	localparam logic [2:0] CTRL_RESET     = 3'h0;
	localparam logic [7:0] ERR_RESET      = 8'h00;

	// frame length limits and collision position range
	localparam int MIN_FRAME_BITS = 4;
	localparam int EMD_MIN_BYTES  = 3;
	localparam int COLL_POS_BITS  = 64;
	localparam int BIT_CNT_W      = 10;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// transmitter/receiver state codes
	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_TX_WAIT   = 3'b001,
		ST_TX_ACT    = 3'b011,
		ST_RX_WAIT   = 3'b101,
		ST_WAIT_DATA = 3'b110,
		ST_RECV      = 3'b111
	} clerr_state_t;

	// contactless command kinds
	typedef enum logic [1:0] {
		CMD_OTHER = 2'b00,
		CMD_TX    = 2'b01,
		CMD_RX    = 2'b10,
		CMD_TRX   = 2'b11
	} clerr_cmd_t;

	// events from the command engine, fifo and receive decoder
	typedef struct packed {
		logic       cmd_start;
		clerr_cmd_t cmd_kind;
		logic       cmd_stop;
		logic       auth_active;
		logic       nvm_done;
		logic       nvm_fail;
		logic       fifo_wr;
		logic       fifo_full;
		logic       fifo_empty;
		logic       tx_crc_active;
		logic       tx_go;
		logic       tx_need_data;
		logic       tx_done;
		logic       rx_go;
		logic       rx_sof;
		logic       rx_bit;
		logic       rx_byte;
		logic       rx_coll;
		logic       rx_coll_eof;
		logic       rx_stop_err;
		logic       rx_sof_err;
		logic       rx_len_err;
		logic       rx_parity_err;
		logic       rx_crc_err;
		logic       rx_end;
		logic       err_to_fifo;
	} clerr_evt_t;

endpackage

// ---- rtl/clerr_axil_slave.sv ----
// clerr_axil_slave: one-outstanding AXI4-Lite slave for the register bank.
// assumes the owner decodes addresses combinationally and answers hit flags.
`timescale 1ns/1ps
module clerr_axil_slave
	import clerr_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// register side
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_hit,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_hit
);

	if (ADDR_W < 8 || ADDR_W > 32) $error("clerr_axil_slave: ADDR_W must be 8..32");

	logic aw_full_r;
	logic w_full_r;

	// write strobe fires once both halves are held and no response is pending
	assign wr_en = aw_full_r & w_full_r & ~s_axi_bvalid;

	// write address and data capture, in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			wr_addr       <= '0;
			wr_data       <= 32'h0;
			wr_strb       <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_r     <= 1'b1;
				s_axi_awready <= 1'b0;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_r     <= 1'b1;
				s_axi_wready <= 1'b0;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
			end
			if (wr_en)
			begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wr_en)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read channel: data latched at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_hit ? rd_data : 32'h0;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// ---- rtl/clerr_state_track.sv ----
// clerr_state_track: transmitter/receiver state machine mirrored as a state code.
// assumes command and phase events are single-cycle pulses from the engine.
`timescale 1ns/1ps
module clerr_state_track
	import clerr_pkg::*;
(
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// phase events
	input  wire clerr_evt_t   evt,
	input  wire logic         multi_frame_receive,
	input  wire logic         frame_ok,
	input  wire logic         frame_drop,
	input  wire logic         rx_halt,
	// state
	output clerr_state_t      state_r,
	output logic              trx_r,
	output logic              enter_wait_data
);

	clerr_state_t state_nxt;
	logic         trx_nxt;

	// next state; stop wins, then a new command, then phase progress
	always_comb
	begin
		state_nxt = state_r;
		trx_nxt   = trx_r;
		if (evt.cmd_stop)
			state_nxt = ST_IDLE;
		else if (evt.cmd_start)
		begin
			trx_nxt = (evt.cmd_kind == CMD_TRX);
			if (evt.cmd_kind == CMD_TX || evt.cmd_kind == CMD_TRX)
				state_nxt = ST_TX_WAIT;
			else if (evt.cmd_kind == CMD_RX)
				state_nxt = ST_RX_WAIT;
			else
				state_nxt = ST_IDLE;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:      state_nxt = ST_IDLE;
				ST_TX_WAIT:   if (evt.tx_go) state_nxt = ST_TX_ACT;
				ST_TX_ACT:    if (evt.tx_done) state_nxt = trx_r ? ST_RX_WAIT : ST_IDLE;
				ST_RX_WAIT:   if (evt.rx_go) state_nxt = ST_WAIT_DATA;
				ST_WAIT_DATA:
				begin
					if (rx_halt)
						state_nxt = ST_IDLE;
					else if (evt.rx_sof)
						state_nxt = ST_RECV;
				end
				ST_RECV:
				begin
					if (rx_halt)
						state_nxt = ST_IDLE;
					else if (frame_drop)
						state_nxt = ST_WAIT_DATA;
					else if (frame_ok)
						state_nxt = multi_frame_receive ? ST_WAIT_DATA : ST_IDLE;
				end
				default:      state_nxt = ST_IDLE;
			endcase
		end
	end

	// receive phase of a transceive begins on the step out of receive-wait
	assign enter_wait_data = trx_r && state_r == ST_RX_WAIT && state_nxt == ST_WAIT_DATA;

	// state register, idle after reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= ST_IDLE;
			trx_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			trx_r   <= trx_nxt;
		end
	end

endmodule

// ---- verification/clerr_tag_model.sv ----
// clerr_tag_model: tag side of the rf link, sends one frame per request.
// assumes events are sampled at the rising edge of aclk.
`timescale 1ns/1ps
module clerr_tag_model
	import clerr_pkg::*;
(
	// clock and request
	input  wire logic       aclk,
	input  wire logic       go,
	input  wire logic [4:0] nbits,
	// frame events
	output logic            sof,
	output logic            dbit,
	output logic            dbyte,
	output logic            eof
);
	initial {sof, dbit, dbyte, eof} = 4'h0;
	// sof, data bits with a byte mark every eight, then frame end
	always @(posedge aclk)
		if (go)
		begin
			sof <= 1'b1;
			@(posedge aclk) sof <= 1'b0;
			for (int i = 1; i <= nbits; i++)
			begin
				dbit <= 1'b1;
				dbyte <= (i % 8 == 0);
				@(posedge aclk);
			end
			{dbit, dbyte, eof} <= 3'h1;
			@(posedge aclk) eof <= 1'b0;
		end
endmodule

// ---- verification/clerr_flags_tb_top.sv ----
// clerr_flags_tb_top: bus reads, event pulses and tag frames on the flag bank.
// assumes the design and clerr_tag_model are compiled first.
`timescale 1ns/1ps
module clerr_flags_tb_top import clerr_pkg::*; ();
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
	logic awready, wready, bvalid, arready, rvalid, eer, rde, fwa, bs, rh;
	logic sof, dbit, dbyte, eof;
	logic [7:0] awaddr, araddr, lef;
	logic [4:0] nb;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	clerr_evt_t ev, evt, e;
	clerr_state_t lsc;
	int errors, total_checks, cyc, n_eer, n_rde, n_bs, n_rh;
	clerr_flags dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt,
		.link_error_flags(lef), .link_state_code(lsc), .error_event_request(eer),
		.receive_done_event(rde), .fifo_write_allow(fwa), .byte_store(bs), .rx_halt(rh));
	clerr_tag_model tag (.aclk, .go, .nbits(nb), .sof, .dbit, .dbyte, .eof);
	// tag frame events merged over the bench strobes
	always_comb
	begin
		evt = ev;
		evt.rx_sof = sof;
		evt.rx_bit = dbit;
		evt.rx_byte = dbyte;
		evt.rx_end = eof;
	end
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// pulse counters and hang guard
	always @(posedge aclk)
	begin
		n_eer <= n_eer + eer;
		n_rde <= n_rde + rde;
		n_bs <= n_bs + bs;
		n_rh <= n_rh + rh;
		cyc <= cyc + 1;
		if (cyc > 4000)
		begin
			errors++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] s, x, input string n);
		total_checks++;
		if (s !== x)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	// axi read with data and response compare
	task automatic rc(input logic [7:0] a, input logic [31:0] x,
		input logic [1:0] rx = RESP_OKAY);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		chk(rdata, x, "rdata");
		chk({30'h0, rresp}, {30'h0, rx}, "rresp");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		// each channel drops its valid at its own handshake
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (awvalid && !awready || wvalid && !wready);
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "bresp");
	endtask
	// one-cycle event strobe from e
	task automatic pulse();
		@(posedge aclk);
		ev <= e;
		@(posedge aclk);
		ev <= '0;
		e = '0;
	endtask
	task automatic frame(input logic [4:0] n);
		@(posedge aclk);
		nb <= n;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (n + 6) @(posedge aclk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
		{awaddr, araddr, wdata, nb} = '0;
		ev = '0;
		e = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc('h28, 0);
		rc('h2c, 0);
		rc('h30, 0, RESP_SLVERR);
		$display("reset test over");
		e.nvm_done = 1'b1;
		e.nvm_fail = 1'b1;
		pulse();
		wr('h28, 'hff);
		rc('h28, 'h80);
		e.cmd_start = 1'b1;
		e.cmd_kind = CMD_TRX;
		pulse();
		rc('h2c, ST_TX_WAIT);
		e.tx_go = 1'b1;
		pulse();
		rc('h2c, ST_TX_ACT);
		e.tx_done = 1'b1;
		pulse();
		rc('h2c, ST_RX_WAIT);
		e.fifo_wr = 1'b1;
		pulse();
		rc('h28, 'hc0);
		chk(n_eer, 1, "err_req");
		e.rx_go = 1'b1;
		pulse();
		rc('h2c, ST_WAIT_DATA);
		frame(2);
		rc('h28, 'hd0);
		rc('h2c, ST_WAIT_DATA);
		frame(8);
		chk(n_rde, 1, "rx_done");
		rc('h2c, ST_IDLE);
		$display("transceive test over");
		e.cmd_start = 1'b1;
		e.cmd_kind = CMD_RX;
		pulse();
		rc('h28, 'h80);
		e.cmd_stop = 1'b1;
		pulse();
		e.fifo_wr = 1'b1;
		e.fifo_full = 1'b1;
		pulse();
		rc('h28, 'ha0);
		chk(fwa, 0, "wr_allow");
		e.tx_need_data = 1'b1;
		e.fifo_empty = 1'b1;
		pulse();
		rc('h28, 'ha8);
		chk(n_eer, 3, "err_req");
		$display("fifo test over");
		// mid-run reset, then collision and protocol errors inside one frame
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc('h28, 0);
		chk(fwa, 1, "wr_allow");
		wr('h40, 'h2);
		rc('h40, 'h2);
		e.cmd_start = 1'b1;
		e.cmd_kind = CMD_RX;
		pulse();
		e.rx_go = 1'b1;
		pulse();
		fork
			frame(31);
			begin
				repeat (3) @(posedge aclk);
				e.rx_coll = 1'b1;
				e.rx_coll_eof = 1'b1;
				pulse();
				e.rx_coll = 1'b1;
				pulse();
				e.rx_stop_err = 1'b1;
				repeat (14) @(posedge aclk);
				pulse();
			end
		join
		rc('h34, 'h83);
		rc('h28, 'h07);
		chk(lef, 'h07, "flags");
		chk(lsc, ST_IDLE, "state");
		chk(n_rh, 1, "rx_halt");
		chk(n_bs, 2, "byte_store");
		chk(n_eer, 5, "err_req");
		$display("receive error test over");
		give_verdict();
	end
endmodule
